// ---- hw/ihie_params.svh ----
/*
 * Register offsets, field positions and reset values of the I2C
 * host interface block. Assumes inclusion by bare name.
 */
`ifndef IHIE_PARAMS_SVH
`define IHIE_PARAMS_SVH

// word offsets (byte addresses)
`define IHIE_OFF_OWN_ADDR   6'h00
`define IHIE_OFF_MASK       6'h04
`define IHIE_OFF_STATUS     6'h08
`define IHIE_OFF_CLK_LOW    6'h0c
`define IHIE_OFF_CLK_HIGH   6'h10
`define IHIE_OFF_COUNT      6'h14
`define IHIE_OFF_RX_DATA    6'h18
`define IHIE_OFF_TARGET     6'h1c
`define IHIE_OFF_TX_DATA    6'h20
`define IHIE_OFF_MODE       6'h24
`define IHIE_OFF_VECTOR     6'h28
`define IHIE_OFF_EXT_MODE   6'h2c
`define IHIE_OFF_PRESCALE   6'h30
`define IHIE_OFF_ID_ONE     6'h34
`define IHIE_OFF_ID_TWO     6'h38

// event bit positions, shared by mask and status
`define IHIE_BIT_ARB_LOST   0
`define IHIE_BIT_NACK       1
`define IHIE_BIT_ACC_READY  2
`define IHIE_BIT_RX_READY   3
`define IHIE_BIT_TX_READY   4
`define IHIE_BIT_STOP_DET   5
`define IHIE_BIT_ADDR_SLV   6

// mode register fields
`define IHIE_MODE_RUN       0
`define IHIE_MODE_TEN_BIT   1
`define IHIE_MODE_FREE      2

// reset values
`define IHIE_RST_OWN_ADDR   10'h000
`define IHIE_RST_MASK       7'h00
`define IHIE_RST_STATUS     7'h10
`define IHIE_RST_MODE       3'h0
`define IHIE_RST_WORD       16'h0000

`endif

// ---- hw/ihie_pkg.sv ----
/*
 * Types of the I2C host interface block.
 * Assumes ihie_params.svh sits beside it.
 */
package ihie_pkg;
   typedef logic [5:0]  ihie_addr_t;
   typedef logic [31:0] ihie_word_t;
   typedef logic [6:0]  ihie_evt_t;
   typedef logic [9:0]  ihie_slave_id_t;
   typedef logic [7:0]  ihie_byte_t;
endpackage

// ---- hw/ihie_top.sv ----
/*
 * Host side of an I2C controller: register file, interrupt status,
 * mask and vector, DMA request pulses, own-address match, stop
 * detection and emulation suspend gating.
 * Assumes a bus engine on sys_clk that reports copies into and out of
 * the shift registers and slave address phases; scl/sda pins are
 * asynchronous and synchronised here.
 * Limitations: shifting, arbitration and clock division live in the
 * bus engine; the divider, count, target, extended mode and prescaler
 * registers are only stored here and read back.
 * Trade-off: irq is registered from next_status, so it changes on the same edge as its flag but
 * never glitches; a vector read drops it one cycle so that each further
 * pending flag shows as a fresh request.
 */
// Our own choice: strobed register access.
// What this block does
// (R1) the controller drives its own interrupt line, shared with no other source
// (R2) copy from receive shift register to holding register raises receive DMA event
// (R3) copy from transmit holding to shift register raises transmit DMA event
// (R4) suspend with free-run clear stops data exchange on the bus
// (R5) suspend with free-run set is ignored, operation continues
// (R6) software leaves offsets outside the fifteen defined words untouched
// (R7) 7-bit mode matches only own address bits 6-0
// (R8) 10-bit mode matches all ten own address bits
// (R9) own address is a read/write 10-bit field resetting to zero
// (R10) reserved bits of own address and mask read zero, writes ignored
// (R11) mask holds seven read/write enables resetting to zero
// (R12) each mask bit gates its event's interrupt request
// (R13) events set flags regardless of mask; mask only gates forwarding
// (R14) vector read returns lowest pending code, clears it, re-raises if more
// (R15) each DMA event is a single-cycle pulse per byte
// (R16) decode on word offsets; reserved offsets read zero without side effects
`timescale 1ns/1ps
`include "ihie_params.svh"

module ihie_top #(
   parameter int WORD_W   = 16,
   parameter logic [31:0] ID_ONE = 32'h0000_0101, // arbitrary value
   parameter logic [31:0] ID_TWO = 32'h0000_0002  // arbitrary value
) (
   // clock and reset
   input  wire  logic                    sys_clk,
   input  wire  logic                    rst,
   // register port
   input  wire  ihie_pkg::ihie_addr_t    reg_addr,
   input  wire  ihie_pkg::ihie_word_t    reg_wdata,
   input  wire  logic                    reg_wr,
   input  wire  logic                    reg_rd,
   output       ihie_pkg::ihie_word_t    reg_rdata,
   // processor interrupt and DMA requests
   output       logic                    irq,
   output       logic                    rx_dma_request,
   output       logic                    tx_dma_request,
   // emulation
   input  wire  logic                    emu_suspend,
   // bus pins (inputs only, sampled)
   input  wire  logic                    scl_in,
   input  wire  logic                    sda_in,
   // bus engine reports
   input  wire  logic                    rx_copy,
   input  wire  ihie_pkg::ihie_byte_t    rx_shift_register,
   input  wire  logic                    tx_copy,
   input  wire  logic                    addr_valid,
   input  wire  ihie_pkg::ihie_slave_id_t addr_seen,
   input  wire  logic                    evt_arb_lost,
   input  wire  logic                    evt_nack,
   input  wire  logic                    evt_acc_ready,
   // to bus engine
   output       ihie_pkg::ihie_byte_t    tx_shift_register,
   output       logic                    bus_run,
   output       logic                    ten_bit_addressing,
   output       ihie_pkg::ihie_slave_id_t own_slave_id,
   output       logic                    addr_hit
);
   import ihie_pkg::*;

   // elaboration check: below 8 bits a divider or count is of little use,
   // above 32 the register word could not carry it
   if (WORD_W < 8 || WORD_W > 32) begin : g_width_check
      $error("WORD_W must lie in 8..32");
   end

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers and stop detection

   // two-stage synchronisers and the previous sample of each pin
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic       sda_last;
   logic       scl_last;
   logic [1:0] next_scl_sync;
   logic [1:0] next_sda_sync;
   logic       next_sda_last;
   logic       next_scl_last;
   logic       stop_seen;

   // first stage feeds only the second; edges use the second stage
   always_comb begin
      next_scl_sync = {scl_sync[0], scl_in};
      next_sda_sync = {sda_sync[0], sda_in};
      next_sda_last = sda_sync[1];
      next_scl_last = scl_sync[1];
   end

   // reset to the idle-high level, so no false stop follows reset
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         sda_last <= 1'b1;
         scl_last <= 1'b1;
      end else begin
         scl_sync <= next_scl_sync;
         sda_sync <= next_sda_sync;
         sda_last <= next_sda_last;
         scl_last <= next_scl_last;
      end
   end

   // stop: data rises while clock stays high
   // two high clock samples, so a data edge racing a clock edge is no stop
   assign stop_seen = sda_sync[1] & ~sda_last & scl_sync[1] & scl_last;

   ////////////////////////////////////////////////////////////////////
   // software registers

   // flops of the software-visible registers
   logic [9:0]        own_addr;
   ihie_evt_t         mask;
   logic [2:0]        mode;
   logic [WORD_W-1:0] clk_low;
   logic [WORD_W-1:0] clk_high;
   logic [WORD_W-1:0] count;
   logic [9:0]        target;
   ihie_byte_t        tx_hold;
   logic [WORD_W-1:0] ext_mode;
   logic [7:0]        prescale;
   // next values of the same
   logic [9:0]        next_own_addr;
   ihie_evt_t         next_mask;
   logic [2:0]        next_mode;
   logic [WORD_W-1:0] next_clk_low;
   logic [WORD_W-1:0] next_clk_high;
   logic [WORD_W-1:0] next_count;
   logic [9:0]        next_target;
   ihie_byte_t        next_tx_hold;
   logic [WORD_W-1:0] next_ext_mode;
   logic [7:0]        next_prescale;

   // upper bits never stored, so they read back as zero
   // only defined offsets decode, so a reserved write changes nothing
   always_comb begin
      next_own_addr = own_addr;
      next_mask     = mask;
      next_mode     = mode;
      next_clk_low  = clk_low;
      next_clk_high = clk_high;
      next_count    = count;
      next_target   = target;
      next_tx_hold  = tx_hold;
      next_ext_mode = ext_mode;
      next_prescale = prescale;
      if (reg_wr) begin
         unique case (reg_addr)
            `IHIE_OFF_OWN_ADDR: next_own_addr = reg_wdata[9:0]; // R9 R10
            `IHIE_OFF_MASK:     next_mask = reg_wdata[6:0];     // R11 R10
            `IHIE_OFF_MODE:     next_mode = reg_wdata[2:0];
            `IHIE_OFF_CLK_LOW:  next_clk_low = reg_wdata[WORD_W-1:0];
            `IHIE_OFF_CLK_HIGH: next_clk_high = reg_wdata[WORD_W-1:0];
            `IHIE_OFF_COUNT:    next_count = reg_wdata[WORD_W-1:0];
            `IHIE_OFF_TARGET:   next_target = reg_wdata[9:0];
            `IHIE_OFF_TX_DATA:  next_tx_hold = reg_wdata[7:0];
            `IHIE_OFF_EXT_MODE: next_ext_mode = reg_wdata[WORD_W-1:0];
            `IHIE_OFF_PRESCALE: next_prescale = reg_wdata[7:0];
            default: ; // R16
         endcase
      end
   end

   // every register clears on rst; the run bit starts cleared as well
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         own_addr <= `IHIE_RST_OWN_ADDR; // R9
         mask     <= `IHIE_RST_MASK;     // R11
         mode     <= `IHIE_RST_MODE;
         clk_low  <= WORD_W'(`IHIE_RST_WORD);
         clk_high <= WORD_W'(`IHIE_RST_WORD);
         count    <= WORD_W'(`IHIE_RST_WORD);
         target   <= 10'h000;
         tx_hold  <= 8'h00;
         ext_mode <= WORD_W'(`IHIE_RST_WORD);
         prescale <= 8'h00;
      end else begin
         own_addr <= next_own_addr;
         mask     <= next_mask;
         mode     <= next_mode;
         clk_low  <= next_clk_low;
         clk_high <= next_clk_high;
         count    <= next_count;
         target   <= next_target;
         tx_hold  <= next_tx_hold;
         ext_mode <= next_ext_mode;
         prescale <= next_prescale;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // event flags, vector and data path

   // flag state, vector decode and byte holding
   ihie_evt_t  status;
   ihie_evt_t  next_status;
   ihie_evt_t  evt_set;
   ihie_evt_t  vec_clear;
   logic [2:0] vec_code;
   ihie_byte_t rx_hold;
   ihie_byte_t next_rx_hold;
   ihie_byte_t next_tx_shift;
   logic       match;
   logic       vec_read;
   logic       running;

   // emulation suspend halts the engine only without free-run
   // suspend is a same-clock level, so it is read without synchronisers
   assign running = mode[`IHIE_MODE_RUN] &
                    (~emu_suspend | mode[`IHIE_MODE_FREE]); // R4 R5

   // 7-bit mode compares low bits only
   // bits 9-7 are don't-care then, whatever software left in them
   always_comb begin
      if (mode[`IHIE_MODE_TEN_BIT]) begin
         match = (addr_seen == own_addr); // R8
      end else begin
         match = (addr_seen[6:0] == own_addr[6:0]); // R7
      end
   end

   // lowest bit number wins; code is bit index plus one
   // the loop runs downwards so the last hit, the lowest bit, sets the code
   // code zero means that no flag is pending
   always_comb begin
      vec_code  = 3'h0;
      vec_clear = 7'h00;
      for (int i = 6; i >= 0; i--) begin
         if (status[i]) begin
            vec_code  = 3'(i + 1);
            vec_clear = 7'(1 << i);
         end
      end
   end

   // the vector read is a read with a side effect on the flags
   assign vec_read = reg_rd & (reg_addr == `IHIE_OFF_VECTOR);

   // flags set regardless of mask; set wins over any clear except the software reset
   always_comb begin
      // engine reports map one to one onto flag bits, except the address phase, which sets its flag only on an own-address match
      evt_set = 7'h00;
      evt_set[`IHIE_BIT_ARB_LOST]  = evt_arb_lost;
      evt_set[`IHIE_BIT_NACK]      = evt_nack;
      evt_set[`IHIE_BIT_ACC_READY] = evt_acc_ready;
      evt_set[`IHIE_BIT_RX_READY]  = rx_copy; // R13
      evt_set[`IHIE_BIT_TX_READY]  = tx_copy;
      evt_set[`IHIE_BIT_STOP_DET]  = stop_seen;
      evt_set[`IHIE_BIT_ADDR_SLV]  = addr_valid & match;
      next_status = status;
      // write one to clear: zeros in the written word leave flags alone
      if (reg_wr && reg_addr == `IHIE_OFF_STATUS) begin
         next_status = next_status & ~reg_wdata[6:0];
      end
      if (vec_read) begin
         next_status = next_status & ~vec_clear; // R14
      end
      // a rx holding read frees the receive flag
      if (reg_rd && reg_addr == `IHIE_OFF_RX_DATA) begin
         next_status[`IHIE_BIT_RX_READY] = 1'b0;
      end
      // new transmit byte written: holding register is full again
      if (reg_wr && reg_addr == `IHIE_OFF_TX_DATA) begin
         next_status[`IHIE_BIT_TX_READY] = 1'b0;
      end
      next_status = next_status | evt_set; // R13
      // software reset outranks even a new event: the engine is idle then
      if (!mode[`IHIE_MODE_RUN]) begin
         next_status = `IHIE_RST_STATUS; // software reset
      end
      next_rx_hold  = rx_copy ? rx_shift_register : rx_hold; // R2
      next_tx_shift = tx_copy ? tx_hold : tx_shift_register; // R3
   end

   // flags restart with only the transmit-ready bit set
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         status            <= `IHIE_RST_STATUS;
         rx_hold           <= 8'h00;
         tx_shift_register <= 8'h00;
      end else begin
         status            <= next_status;
         rx_hold           <= next_rx_hold;
         tx_shift_register <= next_tx_shift;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registered outputs: read data, interrupt, DMA pulses, bus run and address hit

   // next values of the registered outputs
   ihie_word_t next_rdata;
   logic       next_irq;
   logic       next_rx_dma;
   logic       next_tx_dma;
   logic       next_bus_run;
   logic       next_hit;

   // unknown offsets read zero and touch nothing
   // read data fall back to zero after the read cycle, so no stale word stands
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (reg_rd) begin
         // reserved offsets fall to the default below
         unique case (reg_addr)
            `IHIE_OFF_OWN_ADDR: next_rdata = {22'h0, own_addr}; // R10
            `IHIE_OFF_MASK:     next_rdata = {25'h0, mask};     // R10
            `IHIE_OFF_STATUS:   next_rdata = {25'h0, status};
            `IHIE_OFF_CLK_LOW:  next_rdata = 32'(clk_low);
            `IHIE_OFF_CLK_HIGH: next_rdata = 32'(clk_high);
            `IHIE_OFF_COUNT:    next_rdata = 32'(count);
            `IHIE_OFF_RX_DATA:  next_rdata = {24'h0, rx_hold};
            `IHIE_OFF_TARGET:   next_rdata = {22'h0, target};
            `IHIE_OFF_TX_DATA:  next_rdata = {24'h0, tx_hold};
            `IHIE_OFF_MODE:     next_rdata = {29'h0, mode};
            `IHIE_OFF_VECTOR:   next_rdata = {29'h0, vec_code}; // R14
            `IHIE_OFF_EXT_MODE: next_rdata = 32'(ext_mode);
            `IHIE_OFF_PRESCALE: next_rdata = {24'h0, prescale};
            `IHIE_OFF_ID_ONE:   next_rdata = ID_ONE;
            `IHIE_OFF_ID_TWO:   next_rdata = ID_TWO;
            default:            next_rdata = 32'h0000_0000; // R16
         endcase
      end
   end

   // a vector read drops the line one cycle so a fresh edge follows
   // irq uses next_status, so a set or clear shows one edge sooner
   always_comb begin
      next_irq     = |(next_status & mask) & ~vec_read; // R12 R1 R14
      next_rx_dma  = rx_copy; // R2 R15
      next_tx_dma  = tx_copy; // R3 R15
      next_bus_run = running; // R4 R5
      next_hit     = addr_valid & match; // R7 R8
   end

   // every port here leaves a flip-flop, so the far side sees clean edges
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata      <= 32'h0000_0000;
         irq            <= 1'b0;
         rx_dma_request <= 1'b0;
         tx_dma_request <= 1'b0;
         bus_run        <= 1'b0;
         addr_hit       <= 1'b0;
      end else begin
         reg_rdata      <= next_rdata;
         irq            <= next_irq;
         rx_dma_request <= next_rx_dma;
         tx_dma_request <= next_tx_dma;
         bus_run        <= next_bus_run;
         addr_hit       <= next_hit;
      end
   end

   // straight from the mode and address flops
   assign ten_bit_addressing = mode[`IHIE_MODE_TEN_BIT];
   assign own_slave_id       = own_addr;

endmodule

// ---- sim/ihie_top_asserts.sv ----
/* concurrent checks on the ports of ihie_top
   assumes one sys_clk domain with synchronous active high rst */
`timescale 1ns/1ps
module ihie_chk (
   // clock, reset and register port
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic [5:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // requests, engine and bus side
   input wire logic        irq,
   input wire logic        rx_dma_request,
   input wire logic        tx_dma_request,
   input wire logic        rx_copy,
   input wire logic        tx_copy,
   input wire logic        emu_suspend,
   input wire logic        bus_run,
   input wire logic        ten_bit_addressing,
   input wire logic [9:0]  own_slave_id,
   input wire logic        addr_valid,
   input wire logic [9:0]  addr_seen,
   input wire logic        addr_hit
);
   logic [2:0] mode_q;
   logic [6:0] mask_q;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // shadow mode and mask; the block hides them, so the checker tracks writes itself
   always_ff @(posedge sys_clk) begin
      mode_q <= rst ? 3'h0 : (reg_wr && reg_addr == 6'h24) ? reg_wdata[2:0] : mode_q;
      mask_q <= rst ? 7'h0 : (reg_wr && reg_addr == 6'h04) ? reg_wdata[6:0] : mask_q;
   end
   ////////////////////////////////////////
   AST_RX_DMA: assert property (rx_copy |=> rx_dma_request) else $error("rx copy gave no dma request");
   AST_TX_DMA: assert property (tx_copy |=> tx_dma_request) else $error("tx copy gave no dma request");
   AST_DMA_PULSE: assert property (
      (rx_dma_request |-> $past(rx_copy)) and (tx_dma_request |-> $past(tx_copy))) else $error("extra dma request");
   AST_RUN_GATE: assert property (bus_run == $past(mode_q[0] && (!emu_suspend || mode_q[2])))
      else $error("bus run ignores run, suspend or free");
   AST_ADDR_MATCH: assert property (addr_hit == $past(addr_valid && (ten_bit_addressing ?
      addr_seen == own_slave_id : addr_seen[6:0] == own_slave_id[6:0]))) else $error("address match wrong");
   AST_OWN_WRITE: assert property (reg_wr && reg_addr == 6'h00 |=> own_slave_id == $past(reg_wdata[9:0]))
      else $error("own address write lost");
   AST_MASK_READ: assert property (reg_rd && reg_addr == 6'h04 |=> reg_rdata == {25'h0, $past(mask_q)})
      else $error("mask read wrong");
   AST_RESERVED: assert property (reg_rd && (reg_addr > 6'h38 || reg_addr[1:0] != 2'h0) |=> reg_rdata == 32'h0)
      else $error("reserved offset read not zero");
   AST_IRQ_MASK: assert property (irq |-> mask_q != 7'h0 || $past(mask_q) != 7'h0)
      else $error("irq with every source masked");
   COV_RX_DMA: cover property (rx_dma_request ##1 rx_dma_request);
   COV_ADDR_HIT: cover property (addr_hit && ten_bit_addressing);
   COV_IRQ_AGAIN: cover property ($fell(irq) ##1 irq);
endmodule
////////////////////////////////////////
bind ihie_top ihie_chk ihie_chk_inst (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
   .rx_dma_request, .tx_dma_request, .rx_copy, .tx_copy, .emu_suspend, .bus_run, .ten_bit_addressing,
   .own_slave_id, .addr_valid, .addr_seen, .addr_hit);

// ---- sim/ihie_engine_model.sv ----
/* bus engine and bus pin model on the far side of ihie_top
   assumes the bench calls its tasks; all changes land just after sys_clk edges */
`timescale 1ns/1ps
module ihie_engine_model (
   // clock and run gate
   input  wire logic       sys_clk,
   input  wire logic       bus_run,
   // pins, idle high as with pull-ups
   output      logic       scl_in = 1'b1,
   output      logic       sda_in = 1'b1,
   // engine reports
   output      logic       rx_copy = 1'b0,
   output      logic [7:0] rx_shift_register = 8'h00,
   output      logic       tx_copy = 1'b0,
   output      logic       addr_valid = 1'b0,
   output      logic [9:0] addr_seen = 10'h000,
   output      logic       evt_arb_lost = 1'b0,
   output      logic       evt_nack = 1'b0,
   output      logic       evt_acc_ready = 1'b0
);
   // back-to-back copies; a halted engine moves no data, and the byte goes stale after
   task automatic rx_bytes(input logic [7:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         rx_copy <= bus_run;
         rx_shift_register <= b + 8'(i);
      end
      @(posedge sys_clk);
      rx_copy <= 1'b0;
      rx_shift_register <= ~rx_shift_register;
   endtask
   // one-cycle report: 3 is a transmit copy, 0 to 2 the engine events
   task automatic pulse(input int i);
      @(posedge sys_clk);
      {tx_copy, evt_acc_ready, evt_nack, evt_arb_lost} <= bus_run ? 4'h1 << i : 4'h0;
      @(posedge sys_clk);
      {tx_copy, evt_acc_ready, evt_nack, evt_arb_lost} <= 4'h0;
   endtask
   task automatic addr_phase(input logic [9:0] a);
      @(posedge sys_clk);
      addr_valid <= 1'b1;
      addr_seen <= a;
      @(posedge sys_clk);
      addr_valid <= 1'b0;
      addr_seen <= ~a;
   endtask
   // stop frame at a 250 ns bus clock period; scl stands high outside the frame
   task automatic stop_frame();
      for (int i = 0; i < 4; i++) begin
         repeat (12 + i % 2) @(posedge sys_clk);
         scl_in <= i > 1;
         sda_in <= i % 3 == 0;
      end
      repeat (13) @(posedge sys_clk);
   endtask
endmodule

// ---- sim/tb_top.sv ----
/* self-checking bench for ihie_top with the engine model on its far side
   assumes the engine model and the bound checker are compiled with it */
`timescale 1ns/1ps
module tb_top;
   import ihie_pkg::*;
   logic           sys_clk = 1'b0;
   logic           rst = 1'b1;
   logic           reg_wr = 1'b0;
   logic           reg_rd = 1'b0;
   logic           emu_suspend = 1'b0;
   ihie_addr_t     reg_addr = 6'h00;
   ihie_word_t     reg_wdata = 32'h0;
   ihie_word_t     reg_rdata;
   logic           irq, rx_dma_request, tx_dma_request, bus_run, ten_bit_addressing, addr_hit;
   logic           scl_in, sda_in, rx_copy, tx_copy, addr_valid, evt_arb_lost, evt_nack, evt_acc_ready;
   ihie_byte_t     rx_shift_register, tx_shift_register;
   ihie_slave_id_t addr_seen, own_slave_id;
   int             errors = 0;
   int             comparisons = 0;
   int             dma_pulses = 0;
   ihie_slave_id_t seen_tab [4] = '{10'h035, 10'h034, 10'h035, 10'h2b5};
   logic [3:0]     hit_tab = 4'h9;
   always #2.5 sys_clk = ~sys_clk;
   // every request pulse counted, so a stretched pulse shows as a surplus
   always @(posedge sys_clk) dma_pulses <= dma_pulses + int'(rx_dma_request === 1'b1) + int'(tx_dma_request === 1'b1);
   ihie_top ihie_top_inst (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
      .rx_dma_request, .tx_dma_request, .emu_suspend, .scl_in, .sda_in, .rx_copy, .rx_shift_register,
      .tx_copy, .addr_valid, .addr_seen, .evt_arb_lost, .evt_nack, .evt_acc_ready, .tx_shift_register,
      .bus_run, .ten_bit_addressing, .own_slave_id, .addr_hit);
   ihie_engine_model ihie_engine_model_inst (.sys_clk, .bus_run, .scl_in, .sda_in, .rx_copy,
      .rx_shift_register, .tx_copy, .addr_valid, .addr_seen, .evt_arb_lost, .evt_nack, .evt_acc_ready);
   ////////////////////////////////////////
   task automatic check_word(input string name, input ihie_word_t exp, input ihie_word_t got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input ihie_addr_t a, input ihie_word_t d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe, so they are sampled there
   task automatic rd_chk(input ihie_addr_t a, input ihie_word_t exp, input string name, input ihie_word_t m = '1);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      check_word(name, exp, reg_rdata & m);
   endtask
   // irq is registered from the next status, so two edges cover any update
   task automatic settle();
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task automatic test_done();
      if (errors == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      rd_chk(6'h00, 32'h0, "own address");
      rd_chk(6'h04, 32'h0, "mask");
      rd_chk(6'h08, 32'h10, "status");
      wr(6'h24, 32'h1);
      wr(6'h00, 32'hffff_ffff);
      rd_chk(6'h00, 32'h3ff, "own address");
      wr(6'h04, 32'hffff_ffff);
      rd_chk(6'h04, 32'h7f, "mask");
      rd_chk(6'h3c, 32'h0, "reserved offset");
      rd_chk(6'h06, 32'h0, "unaligned offset");
      wr(6'h04, 32'h0);
      wr(6'h08, 32'h10);
      rd_chk(6'h08, 32'h0, "status");
      for (int i = 0; i < 3; i++) begin
         ihie_engine_model_inst.pulse(i);
         settle();
         check_word("irq while masked", 32'h0, 32'(irq));
         rd_chk(6'h08, 32'h1 << i, "status");
         wr(6'h04, 32'h1 << i);
         settle();
         check_word("irq", 32'h1, 32'(irq));
         wr(6'h08, 32'h1 << i);
         settle();
         check_word("irq after clear", 32'h0, 32'(irq));
      end
      wr(6'h04, 32'h7);
      for (int i = 0; i < 3; i++) ihie_engine_model_inst.pulse(i);
      for (int i = 0; i < 3; i++) begin
         rd_chk(6'h28, 32'(i + 1), "vector code");
         settle();
         check_word("irq after vector read", 32'(i < 2), 32'(irq));
      end
      wr(6'h04, 32'h0);
      ihie_engine_model_inst.rx_bytes(8'h5a, 2);
      rd_chk(6'h08, 32'h8, "rx ready", 32'h8);
      rd_chk(6'h18, 32'h5b, "receive holding");
      rd_chk(6'h08, 32'h0, "rx ready after read", 32'h8);
      wr(6'h20, 32'ha5);
      ihie_engine_model_inst.pulse(3);
      settle();
      check_word("tx shift", 32'ha5, {24'h0, tx_shift_register});
      check_word("dma pulses", 32'h3, 32'(dma_pulses));
      wr(6'h00, 32'h2b5);
      for (int i = 0; i < 4; i++) begin
         wr(6'h24, {30'h0, i > 1, 1'b1});
         ihie_engine_model_inst.addr_phase(seen_tab[i]);
         #1;
         check_word("address hit", 32'(hit_tab[i]), 32'(addr_hit));
         check_word("ten bit mode", 32'(i > 1), 32'(ten_bit_addressing));
      end
      ihie_engine_model_inst.stop_frame();
      rd_chk(6'h08, 32'h20, "stop detected", 32'h20);
      @(posedge sys_clk);
      emu_suspend <= 1'b1;
      wr(6'h24, 32'h1);
      settle();
      check_word("bus run, suspended", 32'h0, 32'(bus_run));
      wr(6'h24, 32'h5);
      settle();
      check_word("bus run, free", 32'h1, 32'(bus_run));
      test_done();
   end
   // cuts a hang short; running out counts as a mismatch
   initial begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      test_done();
   end
endmodule
